// >>> hw/repeat_weight_report_cmds.v
`timescale 1ns/1ns
`include "weigh_repeat_map.vh"
module repeat_weight_report_cmds #(
    parameter [31:0] STAB_TIMEOUT_CYC = `STAB_TIMEOUT_MS * (`CLK_HZ / 1000)
) (
    input wire mclk,
    input wire rst,
    input wire cmd_valid,
    input wire [2:0] cmd_code,
    input wire preset_present,
    input wire preset_unit_ok,
    input wire [23:0] preset_value,
    output wire cmd_ready,
    input wire [23:0] wt_host,
    input wire [23:0] wt_disp,
    input wire [2:0] dp_host,
    input wire [2:0] dp_disp,
    input wire [23:0] host_unit_txt,
    input wire [23:0] disp_unit_txt,
    input wire stable,
    input wire overload,
    input wire underload,
    input wire dev_busy,
    input wire tx_ready,
    output wire tx_valid,
    output wire [7:0] tx_data,
    output wire repeat_active
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_BUILD = 3'h1;
    localparam [2:0] S_RD = 3'h2;
    localparam [2:0] S_LD = 3'h3;
    localparam [2:0] S_WT = 3'h4;

    localparam [1:0] P_FIRST = 2'h0;
    localparam [1:0] P_CHANGE = 2'h1;
    localparam [1:0] P_STAB = 2'h2;

    reg [2:0] st_q;
    reg [4:0] step_q;
    reg [4:0] ptr_q;
    reg [4:0] len_q;
    reg [2:0] kind_q;
    reg act_q;
    reg unit_q;
    reg [1:0] phase_q;
    reg [23:0] ref_q;
    reg [23:0] thr_q;
    reg [23:0] preset_q;
    reg use_preset_q;
    reg [31:0] tmr_q;
    reg pend_dyn_q;
    reg neg_q;
    reg sign_done_q;
    reg [2:0] dp_q;
    reg [23:0] utxt_q;
    reg tx_valid_q;
    reg [7:0] tx_data_q;
    reg cmd_ready_q;

    reg wr_en;
    reg [7:0] wr_data;
    reg [4:0] wr_addr;
    reg conv_shift;
    reg sign_wr;
    reg [7:0] uch;

    wire [7:0] rd_data;
    wire [3:0] digit;
    wire rest_zero;

    assign cmd_ready = cmd_ready_q;
    assign tx_valid = tx_valid_q;
    assign tx_data = tx_data_q;
    assign repeat_active = act_q;

    // selected unit view of the weight
    wire [23:0] selw = unit_q ? wt_disp : wt_host;
    wire [2:0] seldp = unit_q ? dp_disp : dp_host;
    wire [23:0] selu = unit_q ? disp_unit_txt : host_unit_txt;
    wire [23:0] mag = selw[23] ? (24'h00_0000 - selw) : selw;
    wire [23:0] mag8 = mag >> `DEFAULT_PCT_SHIFT;
    wire [23:0] dflt = (mag8 < `DEFAULT_MIN_DIG) ? `DEFAULT_MIN_DIG : mag8;
    wire [24:0] d25 = {selw[23], selw} - {ref_q[23], ref_q};
    wire [24:0] adiff = d25[24] ? (25'h000_0000 - d25) : d25;
    wire changed = ({1'b0, thr_q} <= adiff);
    wire bad_preset = preset_present && (!preset_unit_ok ||
        preset_value == 24'h00_0000 || preset_value > `CAPACITY_DIG);
    wire short_line = (kind_q >= `K_BUSY);
    wire [4:0] k = step_q - 5'd4;
    wire [4:0] dp5 = {2'b00, dp_q};
    wire is_dp = (dp_q != 3'h0) && (k == dp5);
    wire need = (k == 5'd0) || ((dp_q != 3'h0) && ((k < dp5) || (k == dp5 + 5'd1)));
    wire [2:0] val_kind = overload ? `K_OVER : (underload ? `K_UNDER : `K_STAB);
    wire [2:0] dyn_kind = overload ? `K_OVER : (underload ? `K_UNDER : `K_DYN);

    digit_conv u_conv (
        .mclk(mclk),
        .rst(rst),
        .load(st_q == S_IDLE),
        .load_val(mag),
        .shift(conv_shift),
        .digit(digit),
        .rest_zero(rest_zero)
    );

    line_mem u_mem (
        .mclk(mclk),
        .rst(rst),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(ptr_q),
        .rd_data(rd_data)
    );

    // reply line character generator
    always @* begin
        wr_en = 1'b0;
        wr_addr = ptr_q;
        wr_data = `CH_SP;
        conv_shift = 1'b0;
        sign_wr = 1'b0;
        uch = `CH_SP;
        if (st_q == S_BUILD) begin
            wr_en = 1'b1;
            if (step_q == 5'd0) begin
                wr_data = `CH_S;
            end else if (step_q == 5'd1) begin
                wr_data = `CH_SP;
            end else if (step_q == 5'd2) begin
                case (kind_q)
                    `K_STAB: wr_data = `CH_S;
                    `K_DYN: wr_data = `CH_D;
                    `K_BUSY: wr_data = `CH_I;
                    `K_PARAM: wr_data = `CH_L;
                    `K_OVER: wr_data = `CH_PLUS;
                    default: wr_data = `CH_MINUS;
                endcase
            end else if (short_line) begin
                wr_data = (step_q == 5'd3) ? `CH_CR : `CH_LF;
            end else if (step_q == 5'd3 || step_q == 5'd14) begin
                wr_data = `CH_SP;
            end else if (step_q < 5'd14) begin
                // field filled right to left
                wr_addr = 5'd17 - step_q;
                if (is_dp) begin
                    wr_data = `CH_DOT;
                end else if (!rest_zero || need) begin
                    wr_data = `CH_ZERO + {4'h0, digit};
                    conv_shift = 1'b1;
                end else if (neg_q && !sign_done_q) begin
                    wr_data = `CH_MINUS;
                    sign_wr = 1'b1;
                end else begin
                    wr_data = `CH_SP;
                end
            end else if (step_q < 5'd18) begin
                case (step_q)
                    5'd15: uch = utxt_q[23:16];
                    5'd16: uch = utxt_q[15:8];
                    default: uch = utxt_q[7:0];
                endcase
                wr_data = uch;
                wr_en = (uch != `CH_SP);
            end else begin
                wr_data = (step_q == 5'd18) ? `CH_CR : `CH_LF;
            end
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= S_IDLE;
            step_q <= 5'd0;
            ptr_q <= 5'd0;
            len_q <= 5'd0;
            kind_q <= `K_STAB;
            act_q <= 1'b0;
            unit_q <= 1'b0;
            phase_q <= P_FIRST;
            ref_q <= 24'h00_0000;
            thr_q <= `DEFAULT_MIN_DIG;
            preset_q <= 24'h00_0000;
            use_preset_q <= 1'b0;
            tmr_q <= 32'h0000_0000;
            pend_dyn_q <= 1'b0;
            neg_q <= 1'b0;
            sign_done_q <= 1'b0;
            dp_q <= 3'h0;
            utxt_q <= 24'h00_0000;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            cmd_ready_q <= 1'b0;
        end else begin
            case (st_q)
                S_IDLE: begin
                    cmd_ready_q <= 1'b1;
                    step_q <= 5'd0;
                    ptr_q <= 5'd0;
                    sign_done_q <= 1'b0;
                    neg_q <= selw[23];
                    dp_q <= seldp;
                    utxt_q <= selu;
                    if (cmd_valid && cmd_ready_q) begin
                        cmd_ready_q <= 1'b0;
                        act_q <= 1'b0;
                        pend_dyn_q <= 1'b0;
                        if (cmd_code == `CMD_REPEAT_HOST || cmd_code == `CMD_REPEAT_DISP) begin
                            if (bad_preset) begin
                                kind_q <= `K_PARAM;
                                st_q <= S_BUILD;
                            end else if (dev_busy) begin
                                kind_q <= `K_BUSY;
                                st_q <= S_BUILD;
                            end else begin
                                act_q <= 1'b1;
                                unit_q <= (cmd_code == `CMD_REPEAT_DISP);
                                phase_q <= P_FIRST;
                                use_preset_q <= preset_present;
                                preset_q <= preset_value;
                            end
                        end else if (cmd_code == `CMD_OTHER) begin
                            act_q <= act_q;
                            pend_dyn_q <= pend_dyn_q;
                        end
                    end else if (act_q && pend_dyn_q) begin
                        pend_dyn_q <= 1'b0;
                        kind_q <= dyn_kind;
                        cmd_ready_q <= 1'b0;
                        st_q <= S_BUILD;
                    end else if (act_q && !dev_busy) begin
                        case (phase_q)
                            P_FIRST: begin
                                if (stable || overload || underload) begin
                                    kind_q <= val_kind;
                                    ref_q <= selw;
                                    thr_q <= use_preset_q ? preset_q : dflt;
                                    phase_q <= P_CHANGE;
                                    cmd_ready_q <= 1'b0;
                                    st_q <= S_BUILD;
                                end
                            end
                            P_CHANGE: begin
                                if (changed) begin
                                    kind_q <= dyn_kind;
                                    tmr_q <= 32'h0000_0000;
                                    phase_q <= P_STAB;
                                    cmd_ready_q <= 1'b0;
                                    st_q <= S_BUILD;
                                end
                            end
                            P_STAB: begin
                                if (stable) begin
                                    kind_q <= val_kind;
                                    ref_q <= selw;
                                    thr_q <= use_preset_q ? preset_q : dflt;
                                    phase_q <= P_CHANGE;
                                    cmd_ready_q <= 1'b0;
                                    st_q <= S_BUILD;
                                end else if (tmr_q >= STAB_TIMEOUT_CYC - 32'h0000_0001) begin
                                    kind_q <= `K_BUSY;
                                    pend_dyn_q <= 1'b1;
                                    tmr_q <= 32'h0000_0000;
                                    cmd_ready_q <= 1'b0;
                                    st_q <= S_BUILD;
                                end else begin
                                    tmr_q <= tmr_q + 32'h0000_0001;
                                end
                            end
                            default: phase_q <= P_FIRST;
                        endcase
                    end
                end
                S_BUILD: begin
                    step_q <= step_q + 5'd1;
                    if (wr_en) begin
                        ptr_q <= ptr_q + 5'd1;
                    end
                    if (sign_wr) begin
                        sign_done_q <= 1'b1;
                    end
                    if ((short_line && step_q == 5'd4) || step_q == 5'd19) begin
                        len_q <= ptr_q + 5'd1;
                        ptr_q <= 5'd0;
                        st_q <= S_RD;
                    end
                end
                S_RD: begin
                    st_q <= S_LD;
                end
                S_LD: begin
                    tx_data_q <= rd_data;
                    tx_valid_q <= 1'b1;
                    st_q <= S_WT;
                end
                S_WT: begin
                    if (tx_ready) begin
                        tx_valid_q <= 1'b0;
                        if (ptr_q == len_q - 5'd1) begin
                            st_q <= S_IDLE;
                        end else begin
                            ptr_q <= ptr_q + 5'd1;
                            st_q <= S_RD;
                        end
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule // repeat_weight_report_cmds

// >>> common/weigh_repeat_map.vh
// How it works
// - first stable, then dynamic plus stable per change
// - default threshold max(stable/8, 30 digits)
// - preset 1 digit to capacity, else param error
// - mark stable or dynamic; host unit variant
// - busy reply when command cannot run
// - param error reply on invalid argument
// - overload reply replaces weight value
// - underload reply replaces weight value
// - cancel, queries or new repeat stop reporting
// - timeout: busy, dynamic, restart timer
// - preset in supported unit only, else error
// - weight field 10 chars, right aligned
// - display variant uses displayed unit
`ifndef WEIGH_REPEAT_MAP_VH
`define WEIGH_REPEAT_MAP_VH

`define CLK_HZ 50000000
`define STAB_TIMEOUT_MS 2000
`define CAPACITY_DIG 24'h0F_4240
`define DEFAULT_MIN_DIG 24'h00_001E
`define DEFAULT_PCT_SHIFT 3
`define FIELD_LEN 10

// command codes
`define CMD_CANCEL 3'h0
`define CMD_SINGLE 3'h1
`define CMD_IMMEDIATE 3'h2
`define CMD_REPEAT_HOST 3'h3
`define CMD_REPEAT_DISP 3'h4
`define CMD_OTHER 3'h5
`define CMD_STABLE_REPEAT_DISP 3'h6

// reply kinds
`define K_STAB 3'h0
`define K_DYN 3'h1
`define K_BUSY 3'h2
`define K_PARAM 3'h3
`define K_OVER 3'h4
`define K_UNDER 3'h5

// characters
`define CH_S 8'h53
`define CH_D 8'h44
`define CH_I 8'h49
`define CH_L 8'h4C
`define CH_PLUS 8'h2B
`define CH_MINUS 8'h2D
`define CH_SP 8'h20
`define CH_DOT 8'h2E
`define CH_ZERO 8'h30
`define CH_CR 8'h0D
`define CH_LF 8'h0A

`endif

// >>> hw/line_mem.v
`timescale 1ns/1ns
module line_mem (
    input wire mclk,
    input wire rst,
    input wire wr_en,
    input wire [4:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [4:0] rd_addr,
    output wire [7:0] rd_data
);
    reg [7:0] mem [0:31];
    reg [7:0] rd_q;

    assign rd_data = rd_q;

    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= mem[rd_addr];
        end
    end
endmodule // line_mem

// >>> hw/digit_conv.v
`timescale 1ns/1ns
module digit_conv (
    input wire mclk,
    input wire rst,
    input wire load,
    input wire [23:0] load_val,
    input wire shift,
    output wire [3:0] digit,
    output wire rest_zero
);
    reg [23:0] v_q;
    wire [23:0] rem;

    // low decimal digit and remaining value
    assign rem = v_q % 24'h00_000A;
    assign digit = rem[3:0];
    assign rest_zero = (v_q == 24'h00_0000);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            v_q <= 24'h00_0000;
        end else if (load) begin
            v_q <= load_val;
        end else if (shift) begin
            v_q <= v_q / 24'h00_000A;
        end
    end
endmodule // digit_conv

// >>> tb/repeat_weight_report_cmds_chk.sv
`timescale 1ns/1ns
`include "weigh_repeat_map.vh"
module weigh_chk #(
    parameter [31:0] STAB_TIMEOUT_CYC = 200
) (
    input wire mclk,
    input wire rst,
    input wire cmd_valid,
    input wire [2:0] cmd_code,
    input wire preset_present,
    input wire preset_unit_ok,
    input wire [23:0] preset_value,
    input wire cmd_ready,
    input wire overload,
    input wire dev_busy,
    input wire tx_ready,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire repeat_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire take = cmd_valid && cmd_ready;
    wire rep = cmd_code == `CMD_REPEAT_HOST || cmd_code == `CMD_REPEAT_DISP;
    wire bad = preset_present && (!preset_unit_ok || preset_value == 24'h00_0000
        || preset_value > `CAPACITY_DIG);
    wire go = take && rep && !bad;
    wire halt = take && (cmd_code == `CMD_CANCEL || cmd_code == `CMD_SINGLE
        || cmd_code == `CMD_IMMEDIATE || cmd_code == `CMD_STABLE_REPEAT_DISP);
    property p_start; go && !dev_busy |=> repeat_active; endproperty
    a_start: assert property (p_start) else $error("repeat did not start");
    property p_bad; take && rep && bad |=> !repeat_active [*8]; endproperty
    a_bad: assert property (p_bad) else $error("bad preset started repeat");
    property p_lreply; take && rep && bad |-> ##[1:60] (tx_valid && tx_data == `CH_L); endproperty
    a_lreply: assert property (p_lreply) else $error("no parameter reply");
    property p_unit;
        take && rep && preset_present && !preset_unit_ok |=> !repeat_active;
    endproperty
    a_unit: assert property (p_unit) else $error("bad unit accepted");
    property p_busy;
        go && dev_busy |=> !repeat_active ##[0:60] (tx_valid && tx_data == `CH_I);
    endproperty
    a_busy: assert property (p_busy) else $error("no busy reply");
    property p_over; go && !dev_busy && overload |-> ##[1:60] (tx_valid && tx_data == `CH_PLUS);
    endproperty
    a_over: assert property (p_over) else $error("no overload reply");
    property p_halt; halt |=> !repeat_active; endproperty
    a_halt: assert property (p_halt) else $error("repeat not stopped");
    property p_crlf;
        tx_valid && tx_ready && tx_data == `CH_CR |-> ##[2:4] (tx_valid && tx_data == `CH_LF);
    endproperty
    a_crlf: assert property (p_crlf) else $error("cr not followed by lf");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    a_hold: assert property (p_hold) else $error("char dropped while stalled");
    c_start: cover property (go);
    c_dyn: cover property (tx_valid && tx_ready && tx_data == `CH_D);
    c_halt: cover property (halt);
endmodule // weigh_chk
bind repeat_weight_report_cmds weigh_chk #(.STAB_TIMEOUT_CYC(STAB_TIMEOUT_CYC)) chk (.*);

// >>> tb/host_model.sv
`timescale 1ns/1ns
module host_model (
    input wire mclk,
    input wire slow,
    input wire cmd_ready,
    input wire tx_valid,
    input wire [7:0] tx_data,
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic preset_present,
    output logic preset_unit_ok,
    output logic [23:0] preset_value,
    output logic tx_ready
);
    logic [7:0] rxq[$];
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 3'h7;
        preset_present = 1'b0;
        preset_unit_ok = 1'b0;
        preset_value = 24'hff_ffff;
        tx_ready = 1'b1;
    end
    // slow mode drops tx_ready every other cycle
    always @(posedge mclk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready) rxq.push_back(tx_data);
    end
    task send_cmd(input [2:0] c, input p, input ok, input [23:0] v);
        int n;
        n = 0;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        preset_present <= p;
        preset_unit_ok <= ok;
        preset_value <= v;
        do begin
            @(posedge mclk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 500);
        cmd_valid <= 1'b0;
        cmd_code <= ~c;
        preset_value <= ~v;
    endtask
endmodule // host_model

// >>> tb/repeat_weight_report_cmds_tb.sv
`timescale 1ns/1ns
`include "weigh_repeat_map.vh"
module repeat_weight_report_cmds_tb;
    logic mclk = 1'b0, rst = 1'b1, slow = 1'b0;
    logic cmd_valid, preset_present, preset_unit_ok, cmd_ready, tx_ready, tx_valid;
    logic stable, overload, underload, dev_busy, repeat_active;
    logic [2:0] cmd_code, dp_host, dp_disp;
    logic [23:0] preset_value, wt_host, wt_disp, host_unit_txt, disp_unit_txt;
    logic [7:0] tx_data;
    logic [31:0] seed = 32'h5e73_a81f;
    int n_mismatch = 0, comparisons = 0;
    always #10 mclk = ~mclk;
    repeat_weight_report_cmds #(.STAB_TIMEOUT_CYC(200)) uut (.*);
    host_model host (.*);
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // model of the 10 char weight field
    function string fld(int w, int dp);
        string s;
        int m, i;
        s = "";
        m = w < 0 ? -w : w;
        for (i = 0; i <= dp || m > 0; i++) begin
            if (i == dp && dp != 0) s = {".", s};
            s = $sformatf("%0d%s", m % 10, s);
            m = m / 10;
        end
        if (w < 0) s = {"-", s};
        while (s.len() < 10) s = {" ", s};
        return s;
    endfunction
    function string wl(string k, int w, int dp, string u);
        return $sformatf("S %s %s %s", k, fld(w, dp), u);
    endfunction
    function int thr(int w);
        return (w >> 3) > 30 ? w >> 3 : 30;
    endfunction
    task expect_line(string s);
        int i, n;
        s = {s, "\r\n"};
        for (i = 0; i < s.len(); i++) begin
            n = 0;
            while (host.rxq.size() == 0 && n < 3000) begin
                @(posedge mclk);
                n++;
            end
            if (host.rxq.size() == 0) check(8'h00, s[i]);
            else check(host.rxq.pop_front(), s[i]);
        end
    endtask
    task stop(input [2:0] c);
        host.send_cmd(c, 1'b0, 1'b0, 24'h00_0000);
        repeat (300) @(posedge mclk);
        check({7'h00, repeat_active}, 8'h00);
        host.rxq.delete();
    endtask
    initial begin
        int w, i;
        wt_host = 24'h00_0000;
        wt_disp = 24'h00_0000;
        dp_host = 3'h2;
        dp_disp = 3'h1;
        host_unit_txt = 24'h20_2067;
        disp_unit_txt = 24'h6c_6220;
        stable = 1'b1;
        overload = 1'b0;
        underload = 1'b0;
        dev_busy = 1'b0;
        repeat (16) @(posedge mclk);
        check({5'h00, cmd_ready, tx_valid, repeat_active}, 8'h00);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        for (i = 0; i < 3; i++) begin
            host.send_cmd(`CMD_REPEAT_HOST, 1'b1, i != 2,
                i == 0 ? 24'h00_0000 : i == 1 ? `CAPACITY_DIG + 24'h00_0001 : 24'h00_0032);
            expect_line("S L");
            check({7'h00, repeat_active}, 8'h00);
        end
        @(posedge mclk);
        dev_busy <= 1'b1;
        host.send_cmd(`CMD_REPEAT_HOST, 1'b0, 1'b0, 24'h00_0000);
        expect_line("S I");
        w = int'(xs() % 30000) + 1000;
        @(posedge mclk);
        dev_busy <= 1'b0;
        wt_host <= 24'(w);
        wt_disp <= 24'h00_0007;
        host.send_cmd(`CMD_REPEAT_HOST, 1'b1, 1'b1, 24'h00_0064);
        expect_line(wl("S", w, 2, "g"));
        @(posedge mclk);
        stable <= 1'b0;
        wt_host <= 24'(w + 99);
        repeat (60) @(posedge mclk);
        check(8'(host.rxq.size()), 8'h00);
        @(posedge mclk);
        wt_host <= 24'(w + 100);
        slow <= 1'b1;
        expect_line(wl("D", w + 100, 2, "g"));
        expect_line("S I");
        expect_line(wl("D", w + 100, 2, "g"));
        @(posedge mclk);
        slow <= 1'b0;
        stable <= 1'b1;
        wt_host <= 24'hff_fffb;
        expect_line(wl("S", -5, 2, "g"));
        stop(`CMD_CANCEL);
        for (i = 0; i < 2; i++) begin
            w = i == 0 ? 1000 : 100;
            @(posedge mclk);
            dp_host <= 3'h0;
            stable <= 1'b1;
            wt_host <= 24'(w);
            host.send_cmd(`CMD_REPEAT_HOST, 1'b0, 1'b0, 24'h00_0000);
            expect_line(wl("S", w, 0, "g"));
            @(posedge mclk);
            stable <= 1'b0;
            wt_host <= 24'(w + thr(w) - 1);
            repeat (60) @(posedge mclk);
            check(8'(host.rxq.size()), 8'h00);
            @(posedge mclk);
            wt_host <= 24'(w + thr(w));
            expect_line(wl("D", w + thr(w), 0, "g"));
            stop(i == 0 ? `CMD_SINGLE : `CMD_IMMEDIATE);
        end
        @(posedge mclk);
        stable <= 1'b1;
        overload <= 1'b1;
        host.send_cmd(`CMD_REPEAT_DISP, 1'b0, 1'b0, 24'h00_0000);
        expect_line("S +");
        // unrelated command leaves the repeat running
        host.send_cmd(`CMD_OTHER, 1'b0, 1'b0, 24'h00_0000);
        repeat (4) @(posedge mclk);
        check({7'h00, repeat_active}, 8'h01);
        stop(`CMD_STABLE_REPEAT_DISP);
        w = int'(xs() % 9000) + 100;
        @(posedge mclk);
        overload <= 1'b0;
        underload <= 1'b1;
        wt_disp <= 24'(w);
        host.send_cmd(`CMD_REPEAT_DISP, 1'b0, 1'b0, 24'h00_0000);
        expect_line("S -");
        // weight already settled, so no dynamic line precedes the restart
        @(posedge mclk);
        underload <= 1'b0;
        host.send_cmd(`CMD_REPEAT_DISP, 1'b0, 1'b0, 24'h00_0000);
        expect_line(wl("S", w, 1, "lb"));
        stop(`CMD_CANCEL);
        finish_test();
    end
    initial begin
        #(20 * 60000);
        n_mismatch++;
        finish_test();
    end
endmodule // repeat_weight_report_cmds_tb
